// [verilog/load_unit.sv]
// Purpose: Effective address, sequencing and formatting of core loads
// Assumes: Memory holds memReq until memAck, data valid with memAck
// Notes: One request in flight; reqReady low while busy

`timescale 1ns/100ps

// Functional notes
// (RULE1) Indexed address is index value plus base value, or zero for base field 0.
// (RULE2) Displacement address is sign-extended displacement plus base value or zero.
// (RULE3) Signed halfword fills upper sixteen bits with the halfword sign bit.
// (RULE4) Unsigned halfword clears upper sixteen destination bits.
// (RULE5) Update forms write the effective address back to the base register.
// (RULE6) Update with base zero, or integer base equal destination, is illegal.
// (RULE7) Swapped halfword exchanges its two bytes, upper half cleared.
// (RULE8) Swapped word reverses all four bytes.
// (RULE9) Swapped loads take the same cycles as plain loads.
// (RULE10) Multiple load fills destination through 31; misaligned address traps. Destination 0 wraps the byte count to zero, so one register is loaded.
// (RULE11) Immediate string count from field, zero meaning 32; ceil(n/4) registers.
// (RULE12) String bytes pack left to right, registers wrap, tail bytes cleared.
// (RULE13) Indexed string count from exception register low seven bits; zero writes nothing.
// (RULE14) Indexed string with source in loaded range raises illegal form.
// (RULE15) Reserve load sets reservation flag and replaces its address.
// (RULE16) Reserve load with non-word-aligned address traps on alignment.
// (RULE17) Single float load widens word to double into float destination.
module load_unit (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic clkEn,
    input wire logic reqValid,
    input wire load_unit_pkg::load_op_t reqOp,
    input wire logic useIndex,
    input wire logic update,
    input wire logic [4:0] destRegField,
    input wire logic [4:0] baseRegField,
    input wire logic [4:0] indexRegField,
    input wire logic [15:0] displacement,
    input wire logic [4:0] byteCountField,
    input wire logic [31:0] baseValue,
    input wire logic [31:0] indexValue,
    input wire logic [31:0] fixedPointExceptionReg,
    input wire logic reserveClear,
    input wire logic memAck,
    input wire logic [31:0] memRdata,
    output logic reqReady,
    output logic memReq,
    output logic [31:0] memAddr,
    output logic [1:0] memSize,
    output logic gprWrEn,
    output logic [4:0] gprWrAddr,
    output logic [31:0] gprWrData,
    output logic fprWrEn,
    output logic [4:0] fprWrAddr,
    output logic [63:0] fprWrData,
    output logic baseWrEn,
    output logic [4:0] baseWrAddr,
    output logic [31:0] baseWrData,
    output logic alignExc,
    output logic illegalExc,
    output logic done,
    output logic reserveValid,
    output logic [31:0] reserveAddr
);

    // ----------------------------------------
    // Address formation
    // ----------------------------------------
    wire take = reqValid && reqReady;
    wire isStrImm = (reqOp == load_unit_pkg::OP_STR_IMM);
    wire isStrIdx = (reqOp == load_unit_pkg::OP_STR_IDX);
    wire isMulti = (reqOp == load_unit_pkg::OP_MULTI);
    wire isFloat = (reqOp == load_unit_pkg::OP_FLOAT_S);
    wire [31:0] baseOperand = (baseRegField == load_unit_pkg::REG_ZERO) ? 32'h0 : baseValue; // RULE1
    wire [31:0] dispExt = {{16{displacement[15]}}, displacement}; // RULE2
    wire [31:0] offset = isStrImm ? 32'h0 : (useIndex ? indexValue : dispExt);
    wire [31:0] effectiveAddress = 32'(baseOperand + offset); // RULE1 RULE2

    // ----------------------------------------
    // Byte and register counts
    // ----------------------------------------
    wire [6:0] immCount = (byteCountField == 5'h00) ? load_unit_pkg::STR_DEFAULT_COUNT
                                                    : {2'h0, byteCountField}; // RULE11
    wire [6:0] xerCount = fixedPointExceptionReg[load_unit_pkg::XER_COUNT_MSB:0]; // RULE13
    wire [6:0] multiCount = 7'({2'h0, 5'h1F - destRegField} + 7'h01) << 2; // RULE10
    wire [6:0] byteCount = isStrImm ? immCount : isStrIdx ? xerCount :
                           isMulti ? multiCount : load_unit_pkg::WORD_BYTES;
    wire [5:0] regCount = 6'((8'({1'b0, byteCount}) + 8'h03) >> 2); // RULE11
    wire [4:0] baseDist = 5'(baseRegField - destRegField);
    wire [4:0] indexDist = 5'(indexRegField - destRegField);
    wire baseInRange = ({1'b0, baseDist} < regCount);
    wire indexInRange = ({1'b0, indexDist} < regCount);

    // ----------------------------------------
    // Form and alignment checks
    // ----------------------------------------
    wire updBad = update && !isMulti && !isStrImm && !isStrIdx &&
                  ((baseRegField == load_unit_pkg::REG_ZERO) ||
                   (!isFloat && baseRegField == destRegField)); // RULE6
    wire multiBad = (isMulti || isStrImm) && baseInRange;
    wire strIdxBad = isStrIdx && (((xerCount != 7'h00) && (baseInRange || indexInRange)) ||
                     destRegField == baseRegField || destRegField == indexRegField); // RULE14
    wire illegalNow = updBad || multiBad || strIdxBad;
    wire misaligned = (effectiveAddress[1:0] != 2'b00);
    wire alignNow = !illegalNow && misaligned &&
                    (isMulti || reqOp == load_unit_pkg::OP_RESERVE); // RULE10 RULE16
    wire emptyStr = isStrIdx && (xerCount == 7'h00); // RULE13
    wire startAccess = take && !illegalNow && !alignNow && !emptyStr;
    wire [1:0] sizeNow = (reqOp == load_unit_pkg::OP_BYTE_Z) ? load_unit_pkg::SIZE_BYTE :
                         (reqOp == load_unit_pkg::OP_HALF_Z || reqOp == load_unit_pkg::OP_HALF_S ||
                          reqOp == load_unit_pkg::OP_HALF_REV) ? load_unit_pkg::SIZE_HALF :
                         load_unit_pkg::SIZE_WORD;

    // ----------------------------------------
    // Sequencing state
    // ----------------------------------------
    load_unit_pkg::state_t state_reg, state_next;
    load_unit_pkg::load_op_t op_reg;
    logic [31:0] ea_reg;
    logic [6:0] rem_reg;
    logic [4:0] dest_reg;
    logic [4:0] baseField_reg;
    logic update_reg;
    wire ack = memReq && memAck;
    wire lastBeat = (rem_reg <= load_unit_pkg::WORD_BYTES);
    wire [2:0] validBytes = lastBeat ? rem_reg[2:0] : 3'h4;
    wire [31:0] fmtGpr;
    wire [63:0] fmtFpr;

    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            load_unit_pkg::ST_IDLE: if (startAccess) state_next = load_unit_pkg::ST_WAIT;
            load_unit_pkg::ST_WAIT: if (ack && lastBeat) state_next = load_unit_pkg::ST_IDLE;
            default: state_next = load_unit_pkg::ST_IDLE;
        endcase
    end

    load_formatter u_fmt (
        .op(op_reg),
        .rawWord(memRdata),
        .validBytes(validBytes),
        .gprData(fmtGpr),
        .fprData(fmtFpr)
    );

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_reg <= load_unit_pkg::ST_IDLE;
            op_reg <= load_unit_pkg::OP_WORD;
            ea_reg <= 32'h0;
            rem_reg <= 7'h00;
            dest_reg <= 5'h00;
            baseField_reg <= 5'h00;
            update_reg <= 1'b0;
        end
        else if (clkEn)
        begin
            state_reg <= state_next;
            if (startAccess)
            begin
                op_reg <= reqOp;
                ea_reg <= effectiveAddress;
                rem_reg <= byteCount;
                dest_reg <= destRegField;
                baseField_reg <= baseRegField;
                update_reg <= update;
            end
            else if (ack && !lastBeat)
            begin
                ea_reg <= 32'(ea_reg + load_unit_pkg::WORD_STEP);
                rem_reg <= 7'(rem_reg - load_unit_pkg::WORD_BYTES);
                dest_reg <= 5'(dest_reg + 5'h01); // RULE12
            end
        end
    end

    // ----------------------------------------
    // Registered outputs
    // ----------------------------------------
    wire isFloatOp = (op_reg == load_unit_pkg::OP_FLOAT_S);
    wire [31:0] nextAddr = 32'(ea_reg + load_unit_pkg::WORD_STEP);

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            reqReady <= 1'b0;
            memReq <= 1'b0;
            memAddr <= 32'h0;
            memSize <= load_unit_pkg::SIZE_WORD;
            gprWrEn <= 1'b0;
            gprWrAddr <= 5'h00;
            gprWrData <= 32'h0;
            fprWrEn <= 1'b0;
            fprWrAddr <= 5'h00;
            fprWrData <= 64'h0;
            baseWrEn <= 1'b0;
            baseWrAddr <= 5'h00;
            baseWrData <= 32'h0;
            alignExc <= 1'b0;
            illegalExc <= 1'b0;
            done <= 1'b0;
        end
        else if (clkEn)
        begin
            reqReady <= (state_next == load_unit_pkg::ST_IDLE) && !startAccess;
            gprWrEn <= ack && !isFloatOp;
            gprWrAddr <= dest_reg;
            gprWrData <= fmtGpr;
            fprWrEn <= ack && isFloatOp; // RULE17
            fprWrAddr <= dest_reg;
            fprWrData <= fmtFpr;
            baseWrEn <= ack && lastBeat && update_reg; // RULE5
            baseWrAddr <= baseField_reg;
            baseWrData <= ea_reg;
            illegalExc <= take && illegalNow;
            alignExc <= take && alignNow;
            done <= (ack && lastBeat) || (take && emptyStr);
            if (startAccess)
            begin
                memReq <= 1'b1;
                memAddr <= effectiveAddress;
                memSize <= sizeNow;
            end
            else if (ack)
            begin
                memReq <= !lastBeat;
                memAddr <= nextAddr;
            end
        end
    end

    // Set wins when a new reservation meets a clear
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            reserveValid <= 1'b0;
            reserveAddr <= 32'h0;
        end
        else if (clkEn)
        begin
            if (ack && op_reg == load_unit_pkg::OP_RESERVE)
            begin
                reserveValid <= 1'b1; // RULE15
                reserveAddr <= ea_reg & load_unit_pkg::RESERVE_MASK;
            end
            else if (reserveClear)
            begin
                reserveValid <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    wire single = !isStrImm && !isStrIdx && !isMulti;

    index_addr_a: assert property (clkEn && startAccess && useIndex && single |=> // RULE1
        memAddr == $past(baseOperand) + $past(indexValue)) else $error("indexed address wrong");
    disp_addr_a: assert property (clkEn && startAccess && !useIndex && single |=> // RULE2
        memAddr == $past(baseOperand) + $past(dispExt)) else $error("displacement address wrong");
    half_sign_a: assert property (gprWrEn && $past(op_reg) == load_unit_pkg::OP_HALF_S |-> // RULE3
        gprWrData[31:16] == {16{gprWrData[15]}}) else $error("sign fill wrong");
    half_zero_a: assert property (gprWrEn && $past(op_reg) == load_unit_pkg::OP_HALF_Z |-> // RULE4
        gprWrData[31:16] == 16'h0000) else $error("zero fill wrong");
    base_wb_a: assert property (clkEn && ack && lastBeat && update_reg |=> // RULE5
        baseWrEn && baseWrData == $past(ea_reg)) else $error("base write missing");
    upd_form_a: assert property (clkEn && take && update && single && // RULE6
        baseRegField == 5'h00 |=> illegalExc && !memReq) else $error("update form not refused");
    half_rev_a: assert property (gprWrEn && $past(op_reg) == load_unit_pkg::OP_HALF_REV |-> // RULE7
        gprWrData == {16'h0, $past(memRdata[7:0]), $past(memRdata[15:8])})
        else $error("swapped halfword wrong");
    rev_latency_a: assert property (clkEn && ack && op_reg == load_unit_pkg::OP_WORD_REV |=> // RULE9
        gprWrEn && gprWrData[7:0] == $past(memRdata[31:24])) else $error("swap latency wrong");
    multi_align_a: assert property (clkEn && take && isMulti && misaligned && // RULE10
        !illegalNow |=> alignExc && !memReq) else $error("multiple not trapped");
    str_count_a: assert property (clkEn && startAccess && isStrImm && // RULE11
        byteCountField == 5'h00 |=> rem_reg == 7'h20) else $error("string count wrong");
    reserve_set_a: assert property (clkEn && ack && op_reg == load_unit_pkg::OP_RESERVE |=> // RULE15
        reserveValid && reserveAddr == ($past(ea_reg) & 32'hFFFF_FFFC))
        else $error("reservation not set");
    reserve_align_a: assert property (clkEn && take && reqOp == load_unit_pkg::OP_RESERVE && // RULE16
        misaligned && !illegalNow |=> alignExc) else $error("reserve misalign missed");

    word_load_c: cover property (clkEn && take && reqOp == load_unit_pkg::OP_WORD ##[1:20] done);
    multi_load_c: cover property (gprWrEn && gprWrAddr == 5'h1F && $past(op_reg) == load_unit_pkg::OP_MULTI);
    str_wrap_c: cover property (gprWrEn && gprWrAddr == 5'h00 && $past(op_reg) == load_unit_pkg::OP_STR_IMM);
    float_load_c: cover property (fprWrEn);

endmodule : load_unit

// [verilog/load_unit_pkg.sv]
// Purpose: Shared constants and types for the load address and format unit
// Assumes: Big-endian data, bit 31 of a port is bit 0 in memory numbering
// Notes: Opcode and state encodings are local to this unit

package load_unit_pkg;

    // ----------------------------------------
    // Operation and state encodings
    // ----------------------------------------
    typedef enum logic [3:0] {
        OP_BYTE_Z   = 4'b0000,
        OP_HALF_Z   = 4'b0001,
        OP_HALF_S   = 4'b0010,
        OP_HALF_REV = 4'b0011,
        OP_WORD     = 4'b0100,
        OP_WORD_REV = 4'b0101,
        OP_RESERVE  = 4'b0110,
        OP_MULTI    = 4'b0111,
        OP_STR_IMM  = 4'b1000,
        OP_STR_IDX  = 4'b1001,
        OP_FLOAT_S  = 4'b1010
    } load_op_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_WAIT = 2'b01
    } state_t;

    // ----------------------------------------
    // Sizes, counts and field positions
    // ----------------------------------------
    localparam logic [1:0] SIZE_BYTE = 2'h0;
    localparam logic [1:0] SIZE_HALF = 2'h1;
    localparam logic [1:0] SIZE_WORD = 2'h2;
    localparam logic [4:0] REG_ZERO = 5'h00;
    localparam logic [6:0] STR_DEFAULT_COUNT = 7'h20;
    localparam logic [6:0] WORD_BYTES = 7'h04;
    localparam int XER_COUNT_MSB = 6;
    localparam logic [31:0] WORD_STEP = 32'h0000_0004;
    localparam logic [31:0] RESERVE_MASK = 32'hFFFF_FFFC;

    // Single to double exponent handling
    localparam logic [10:0] EXP_REBIAS = 11'h380;
    localparam logic [7:0] SGL_EXP_MAX = 8'hFF;
    localparam logic [10:0] DBL_EXP_MAX = 11'h7FF;

endpackage : load_unit_pkg

// [verilog/load_formatter.sv]
// Purpose: Formats a memory word into destination register data
// Assumes: Byte data in bits 7:0, halfword in 15:0, word in 31:0
// Notes: Purely combinational, adds no pipeline stage

`timescale 1ns/100ps

module load_formatter (
    input wire load_unit_pkg::load_op_t op,
    input wire logic [31:0] rawWord,
    input wire logic [2:0] validBytes,
    output logic [31:0] gprData,
    output logic [63:0] fprData
);

    // ----------------------------------------
    // Candidate results
    // ----------------------------------------
    wire [31:0] byteZ = {24'h000000, rawWord[7:0]};
    wire [31:0] halfZ = {16'h0000, rawWord[15:0]}; // RULE4
    wire [31:0] halfS = {{16{rawWord[15]}}, rawWord[15:0]}; // RULE3
    wire [31:0] halfRev = {16'h0000, rawWord[7:0], rawWord[15:8]}; // RULE7
    wire [31:0] wordRev = {rawWord[7:0], rawWord[15:8], rawWord[23:16], rawWord[31:24]}; // RULE8
    wire [31:0] strWord;

    // Keep leading bytes, clear unfilled low-order bytes
    genvar i;
    generate
        for (i = 0; i < 4; i = i + 1)
        begin : g_mask
            assign strWord[31 - 8 * i -: 8] =
                (3'(i) < validBytes) ? rawWord[31 - 8 * i -: 8] : 8'h00; // RULE12
        end
    endgenerate

    // ----------------------------------------
    // Single to double conversion
    // ----------------------------------------
    // Subnormal inputs are not renormalised here
    wire [7:0] sglExp = rawWord[30:23];
    wire [10:0] dblExp = (sglExp == load_unit_pkg::SGL_EXP_MAX) ? load_unit_pkg::DBL_EXP_MAX :
                         (sglExp == 8'h00) ? 11'h000 :
                         11'({3'h0, sglExp} + load_unit_pkg::EXP_REBIAS);
    assign fprData = {rawWord[31], dblExp, rawWord[22:0], 29'h00000000}; // RULE17

    // Same path for swapped and plain loads, so no added latency
    assign gprData = (op == load_unit_pkg::OP_BYTE_Z) ? byteZ :
                     (op == load_unit_pkg::OP_HALF_Z) ? halfZ :
                     (op == load_unit_pkg::OP_HALF_S) ? halfS :
                     (op == load_unit_pkg::OP_HALF_REV) ? halfRev : // RULE9
                     (op == load_unit_pkg::OP_WORD_REV) ? wordRev :
                     (op == load_unit_pkg::OP_MULTI) ? rawWord :
                     (op == load_unit_pkg::OP_STR_IMM) ? strWord :
                     (op == load_unit_pkg::OP_STR_IDX) ? strWord :
                     rawWord;

endmodule : load_formatter

// [dv/load_mem_model.sv]
// Purpose: Data memory partner for the load unit
// Assumes: Ack raised waitCycles falling edges after the first falling edge following a request, held until taken
// Notes: Idle data bus toggles every cycle so stale data never looks valid
`timescale 1ns/100ps
module load_mem_model (
    input wire logic clk,
    input wire logic clkEn,
    input wire logic memReq,
    input wire logic [31:0] memAddr,
    input wire logic [3:0] waitCycles,
    output logic memAck,
    output logic [31:0] memRdata
);
    logic taken = 1'b0;
    logic [3:0] waitCount = 4'h0;
    // ----------------
    // Memory contents
    // ----------------
    function automatic logic [31:0] wordAt(input logic [31:0] a);
        return a ^ 32'hA5C3_8F96;
    endfunction : wordAt
    initial
    begin
        memAck = 1'b0;
        memRdata = 32'h0000_0000;
    end
    always @(posedge clk)
        taken <= memReq && memAck && clkEn;
    always @(negedge clk)
    begin
        if (taken || !memReq)
        begin
            memAck = 1'b0;
            waitCount = 4'h0;
        end
        if (!memAck)
            memRdata = ~memRdata;
        if (memReq && !memAck && waitCount >= waitCycles)
        begin
            memAck = 1'b1;
            memRdata = wordAt(memAddr);
        end
        else if (memReq && !memAck)
            waitCount = waitCount + 4'h1;
    end
endmodule : load_mem_model

// [dv/testbench.sv]
// Purpose: Self-checking bench for the load address and format unit
// Assumes: Inputs change at the falling edge; memory partner answers requests
// Notes: Clock enable held high, so freeze behaviour is not exercised
`timescale 1ns/100ps
module testbench;
    logic clk = 1'b0;
    logic rst_b, clkEn, reqValid, useIndex, update, reserveClear, memAck, reserveValid;
    logic reqReady, memReq, gprWrEn, fprWrEn, baseWrEn, alignExc, illegalExc, done;
    load_unit_pkg::load_op_t reqOp;
    logic [4:0] destRegField, baseRegField, indexRegField, byteCountField;
    logic [4:0] gprWrAddr, fprWrAddr, baseWrAddr, fprAt;
    logic [15:0] displacement;
    logic [31:0] baseValue, indexValue, fixedPointExceptionReg, memRdata, memAddr;
    logic [31:0] gprWrData, baseWrData, reserveAddr;
    logic [63:0] fprWrData, fprSeen;
    logic [1:0] memSize;
    logic [3:0] waitCycles;
    logic [36:0] gprLog[$];
    logic [36:0] baseSeen;
    logic [2:0] flags;
    int errCount = 0, samplesChecked = 0, cycle = 0, firstWr, issueCycle;
    always #5 clk = ~clk;
    load_unit dut_u (.clk(clk), .rst_b(rst_b), .clkEn(clkEn), .reqValid(reqValid),
        .reqOp(reqOp), .useIndex(useIndex), .update(update), .destRegField(destRegField),
        .baseRegField(baseRegField), .indexRegField(indexRegField),
        .displacement(displacement), .byteCountField(byteCountField), .baseValue(baseValue),
        .indexValue(indexValue), .fixedPointExceptionReg(fixedPointExceptionReg),
        .reserveClear(reserveClear), .memAck(memAck), .memRdata(memRdata),
        .reqReady(reqReady), .memReq(memReq), .memAddr(memAddr), .memSize(memSize),
        .gprWrEn(gprWrEn), .gprWrAddr(gprWrAddr), .gprWrData(gprWrData), .fprWrEn(fprWrEn),
        .fprWrAddr(fprWrAddr), .fprWrData(fprWrData), .baseWrEn(baseWrEn),
        .baseWrAddr(baseWrAddr), .baseWrData(baseWrData), .alignExc(alignExc),
        .illegalExc(illegalExc), .done(done), .reserveValid(reserveValid),
        .reserveAddr(reserveAddr));
    load_mem_model mem_u (.clk(clk), .clkEn(clkEn), .memReq(memReq), .memAddr(memAddr),
        .waitCycles(waitCycles), .memAck(memAck), .memRdata(memRdata));
    // ----------------
    // Output monitor
    // ----------------
    always @(negedge clk)
    begin
        cycle++;
        if (gprWrEn === 1'b1)
            gprLog.push_back({gprWrAddr, gprWrData});
        if (gprWrEn === 1'b1 && firstWr < 0)
            firstWr = cycle;
        if (fprWrEn === 1'b1)
            {fprAt, fprSeen} = {fprWrAddr, fprWrData};
        if (baseWrEn === 1'b1)
            baseSeen = {baseWrAddr, baseWrData};
        flags = flags | {done === 1'b1, alignExc === 1'b1, illegalExc === 1'b1};
    end
    // ----------------
    // Shared tasks
    // ----------------
    task automatic completeRun;
        $display("checks %0d mismatches %0d", samplesChecked, errCount);
        if (errCount == 0 && samplesChecked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : completeRun
    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        samplesChecked++;
        if (seen !== exp)
        begin
            errCount++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    function automatic logic [31:0] ea(input logic idx, input logic [4:0] b, input logic [15:0] d);
        return (b == 5'h00 ? 32'h0 : baseValue) + (idx ? indexValue : {{16{d[15]}}, d});
    endfunction : ea
    function automatic logic [31:0] fmt(input int k, input logic [31:0] w);
        // Index order matches the op list of the format test
        case (k)
            1: return {w[7:0], w[15:8], w[23:16], w[31:24]};
            2: return {{16{w[15]}}, w[15:0]};
            3: return {16'h0000, w[15:0]};
            4: return {16'h0000, w[7:0], w[15:8]};
            5: return {24'h000000, w[7:0]};
            default: return w;
        endcase
    endfunction : fmt
    function automatic logic [63:0] dbl(input logic [31:0] w);
        logic [10:0] e;
        e = {3'h0, w[30:23]} + 11'h380;
        if (w[30:23] == 8'hFF || w[30:23] == 8'h00)
            e = {11{w[30]}};
        return {w[31], e, w[22:0], 29'h0};
    endfunction : dbl
    task automatic issue(input load_unit_pkg::load_op_t op, input logic idx, input logic upd,
        input logic [4:0] d, input logic [4:0] b, input logic [4:0] x, input logic [15:0] disp);
        int n;
        for (n = 0; n < 50 && reqReady !== 1'b1; n++)
            @(negedge clk);
        {reqOp, useIndex, update, destRegField, baseRegField} = {op, idx, upd, d, b};
        {indexRegField, displacement, reqValid} = {x, disp, 1'b1};
        gprLog.delete();
        {fprAt, fprSeen, baseSeen, flags, firstWr, issueCycle} = {109'h0, -32'sd1, cycle};
        @(negedge clk);
        reqValid = 1'b0;
        for (n = n; n < 150 && flags == 3'b000; n++)
            @(negedge clk);
        @(negedge clk);
        if (n >= 150)
        begin
            errCount++;
            completeRun();
        end
    endtask : issue
    task automatic chkStr(input logic [4:0] d, input logic [31:0] e, input int n);
        int nr;
        logic [31:0] w;
        nr = (n + 3) / 4;
        check("regCount", gprLog.size(), nr);
        for (int k = 0; k < nr; k++)
        begin
            w = mem_u.wordAt(e + 32'(4 * k));
            if (k == nr - 1 && n % 4 != 0)
                w = w & ~(32'hFFFF_FFFF >> (8 * (n % 4)));
            check("strWord", gprLog[k], {d + 5'(k), w});
        end
    endtask : chkStr
    // ----------------
    // Scenarios
    // ----------------
    task automatic tFormats;
        load_unit_pkg::load_op_t ops[6] = '{load_unit_pkg::OP_WORD, load_unit_pkg::OP_WORD_REV,
            load_unit_pkg::OP_HALF_S, load_unit_pkg::OP_HALF_Z, load_unit_pkg::OP_HALF_REV,
            load_unit_pkg::OP_BYTE_Z};
        int lat0;
        logic [4:0] b;
        waitCycles = 4'h2;
        for (int i = 0; i < 6; i++)
        begin
            b = i[1] ? 5'h07 : 5'h00;
            issue(ops[i], i[0], 1'b0, 5'h03, b, 5'h09, 16'hFFF0);
            if (i == 0)
                lat0 = firstWr - issueCycle;
            check("flags", flags, 3'b100);
            check("fmt", gprLog[0], {5'h03, fmt(i, mem_u.wordAt(ea(i[0], b, 16'hFFF0)))});
            check("latency", firstWr - issueCycle, lat0);
        end
        $display("tFormats finished");
    endtask : tFormats
    task automatic tUpdate;
        waitCycles = 4'h0;
        issue(load_unit_pkg::OP_HALF_S, 1'b1, 1'b1, 5'h04, 5'h06, 5'h09, 16'h0000);
        check("baseWr", baseSeen, {5'h06, ea(1'b1, 5'h06, 16'h0)});
        issue(load_unit_pkg::OP_HALF_Z, 1'b0, 1'b1, 5'h04, 5'h00, 5'h09, 16'h0008);
        check("illBase0", {flags[0], baseSeen != 0, gprLog.size() != 0}, 3'b100);
        issue(load_unit_pkg::OP_WORD, 1'b1, 1'b1, 5'h04, 5'h04, 5'h09, 16'h0000);
        check("illSame", {flags[0], baseSeen != 0, gprLog.size() != 0}, 3'b100);
        issue(load_unit_pkg::OP_FLOAT_S, 1'b0, 1'b1, 5'h04, 5'h00, 5'h09, 16'h0004);
        check("illFlt", {flags[0], fprSeen != 0}, 2'b10);
        issue(load_unit_pkg::OP_FLOAT_S, 1'b0, 1'b1, 5'h06, 5'h06, 5'h09, 16'h0004);
        check("fpr", {fprAt, fprSeen}, {5'h06, dbl(mem_u.wordAt(ea(1'b0, 5'h06, 16'h4)))});
        check("fltBase", baseSeen, {5'h06, ea(1'b0, 5'h06, 16'h4)});
        $display("tUpdate finished");
    endtask : tUpdate
    task automatic tReserve;
        issue(load_unit_pkg::OP_RESERVE, 1'b1, 1'b0, 5'h05, 5'h07, 5'h09, 16'h0000);
        check("resData", gprLog[0], {5'h05, mem_u.wordAt(ea(1'b1, 5'h07, 16'h0))});
        indexValue = 32'h0000_0210;
        issue(load_unit_pkg::OP_RESERVE, 1'b1, 1'b0, 5'h05, 5'h07, 5'h09, 16'h0000);
        check("resAddr", {reserveValid, reserveAddr}, {1'b1, ea(1'b1, 5'h07, 16'h0)});
        reserveClear = 1'b1;
        @(negedge clk);
        reserveClear = 1'b0;
        check("resClear", reserveValid, 1'b0);
        indexValue = 32'h0000_0206;
        issue(load_unit_pkg::OP_RESERVE, 1'b1, 1'b0, 5'h05, 5'h07, 5'h09, 16'h0000);
        check("resAlign", {flags[1], gprLog.size() != 0}, 2'b10);
        indexValue = 32'h0000_0208;
        $display("tReserve finished");
    endtask : tReserve
    task automatic tMulti;
        waitCycles = 4'h1;
        issue(load_unit_pkg::OP_MULTI, 1'b0, 1'b0, 5'h1D, 5'h05, 5'h09, 16'h0010);
        chkStr(5'h1D, ea(1'b0, 5'h05, 16'h0010), 12);
        issue(load_unit_pkg::OP_MULTI, 1'b0, 1'b0, 5'h1D, 5'h05, 5'h09, 16'h0012);
        check("multiAlign", {flags[1], gprLog.size() != 0}, 2'b10);
        $display("tMulti finished");
    endtask : tMulti
    task automatic tString;
        waitCycles = 4'h0;
        byteCountField = 5'h06;
        issue(load_unit_pkg::OP_STR_IMM, 1'b0, 1'b0, 5'h1E, 5'h0A, 5'h09, 16'h0000);
        chkStr(5'h1E, baseValue, 6);
        byteCountField = 5'h00;
        issue(load_unit_pkg::OP_STR_IMM, 1'b0, 1'b0, 5'h1C, 5'h0A, 5'h09, 16'h0000);
        chkStr(5'h1C, baseValue, 32);
        fixedPointExceptionReg = 32'hA000_0085;
        issue(load_unit_pkg::OP_STR_IDX, 1'b1, 1'b0, 5'h01, 5'h0A, 5'h0C, 16'h0000);
        chkStr(5'h01, baseValue + indexValue, 5);
        issue(load_unit_pkg::OP_STR_IDX, 1'b1, 1'b0, 5'h01, 5'h0A, 5'h02, 16'h0000);
        check("strRange", {flags[0], gprLog.size() != 0}, 2'b10);
        fixedPointExceptionReg = 32'hA000_0080;
        issue(load_unit_pkg::OP_STR_IDX, 1'b1, 1'b0, 5'h01, 5'h0A, 5'h0C, 16'h0000);
        check("strZero", {flags, gprLog.size() != 0}, 4'b1000);
        $display("tString finished");
    endtask : tString
    initial
    begin
        {rst_b, clkEn, reqValid, useIndex, update, reserveClear} = 6'b010000;
        {destRegField, baseRegField, indexRegField, byteCountField} = 20'h0;
        {reqOp, displacement, waitCycles} = {load_unit_pkg::OP_WORD, 16'h0, 4'h0};
        {baseValue, indexValue} = {32'h0000_1100, 32'h0000_0208};
        fixedPointExceptionReg = 32'h0000_0000;
        repeat (5) @(negedge clk);
        rst_b = 1'b1;
        tFormats();
        tUpdate();
        tReserve();
        tMulti();
        tString();
        completeRun();
    end
endmodule : testbench
